// ==== rtl/ptq_top.sv ====
// pulse trigger qualifier: wishbone registers, comparator sync, class engines
`timescale 1ns/1ps
module ptq_top (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [3:0] cmp_lvl_i,
   input wire logic [3:0] cmp_hi_i,
   input wire logic [3:0] cmp_lo_i,
   input wire logic [31:0] samp_i,
   output logic trig_o,
   output logic [7:0] level_o
);

   typedef struct packed {
      logic [11:0] sy1;
      logic [11:0] sy2;
      logic [2:0] prv;
      ptq_pkg::ptq_state_t st;
      logic [15:0] cnt;
      logic trig;
      logic [ptq_pkg::CTL_W-1:0] ctl;
      logic [15:0] glw;
      logic [15:0] wlo;
      logic [15:0] whi;
      logic [15:0] slw;
      logic [7:0] lvl;
      logic [7:0] lvl_eff;
      logic [15:0] tcnt;
      logic pk_start;
      logic ack;
      logic [31:0] dat;
   } ptq_regs_t;

   ptq_regs_t s_r;
   ptq_regs_t s_nxt;

   logic pk_busy;
   logic pk_done;
   logic [7:0] pk_mid;
   logic [7:0] samp_sel;

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [31:0] wd,
                                           input logic [3:0] sel);
      logic [15:0] r;
      r = old_v;
      if (sel[0]) begin
         r[7:0] = wd[7:0];
      end
      if (sel[1]) begin
         r[15:8] = wd[15:8];
      end
      return r;
   endfunction

   function automatic logic [15:0] sat_inc(input logic [15:0] c);
      return (c == ptq_pkg::CNT_MAX) ? c : c + 16'h0001;
   endfunction

   // ---------------------------------------------
   // source selection, shared by every class
   // ---------------------------------------------
   logic [1:0] cls;
   logic [1:0] pol;
   logic [1:0] src;
   logic s_lvl;
   logic s_hi;
   logic s_lo;
   logic lvl_r;
   logic lvl_f;
   logic hi_r;
   logic hi_f;
   logic lo_r;
   logic lo_f;
   logic pos_ok;
   logic neg_ok;
   logic glitch_ok;
   logic width_ok;
   logic slew_ok;
   logic wr;
   logic acc;

   always_comb begin
      cls = s_r.ctl[ptq_pkg::CTL_CLS +: 2];
      pol = s_r.ctl[ptq_pkg::CTL_POL +: 2];
      src = s_r.ctl[ptq_pkg::CTL_SRC +: 2];
      // only the second sync stage is read here
      s_lvl = s_r.sy2[{2'h0, src}];
      s_hi = s_r.sy2[4 + {2'h0, src}];
      s_lo = s_r.sy2[8 + {2'h0, src}];
      samp_sel = samp_i[{src, 3'h0} +: 8];
      lvl_r = s_lvl & ~s_r.prv[0];
      lvl_f = ~s_lvl & s_r.prv[0];
      hi_r = s_hi & ~s_r.prv[1];
      hi_f = ~s_hi & s_r.prv[1];
      lo_r = s_lo & ~s_r.prv[2];
      lo_f = ~s_lo & s_r.prv[2];
      pos_ok = (pol == ptq_pkg::POL_POS) || (pol == ptq_pkg::POL_EITHER);
      neg_ok = (pol == ptq_pkg::POL_NEG) || (pol == ptq_pkg::POL_EITHER);
      // accept: narrower than width; reject: wider
      glitch_ok = s_r.ctl[ptq_pkg::CTL_REJ] ? (s_r.cnt > s_r.glw) : (s_r.cnt < s_r.glw);
      width_ok = ((s_r.cnt >= s_r.wlo) && (s_r.cnt <= s_r.whi)) ^ s_r.ctl[ptq_pkg::CTL_OUT];
      slew_ok = s_r.ctl[ptq_pkg::CTL_SLOW] ? (s_r.cnt > s_r.slw) : (s_r.cnt < s_r.slw);
      acc = wb_cyc_i & wb_stb_i & ~s_r.ack;
      wr = acc & wb_we_i;
   end

   ptq_peak u_peak (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(s_r.pk_start),
      .samp_i(samp_sel),
      .busy_o(pk_busy),
      .done_o(pk_done),
      .mid_o(pk_mid)
   );

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      logic hit;
      logic pul_ok;
      logic [15:0] nv;
      hit = 1'b0;
      nv = 16'h0000;
      pul_ok = (cls == ptq_pkg::CLS_GLITCH) ? glitch_ok : width_ok;
      s_nxt = s_r;
      s_nxt.sy1 = {cmp_lo_i, cmp_hi_i, cmp_lvl_i};
      s_nxt.sy2 = s_r.sy1;
      s_nxt.prv = {s_lo, s_hi, s_lvl};
      s_nxt.pk_start = 1'b0;

      case (s_r.st)
         ptq_pkg::ST_IDLE: begin
            s_nxt.cnt = 16'h0001;
            if (cls == ptq_pkg::CLS_GLITCH || cls == ptq_pkg::CLS_WIDTH) begin
               if (lvl_r && pos_ok) begin
                  s_nxt.st = ptq_pkg::ST_PUL_P;
               end else if (lvl_f && neg_ok) begin
                  s_nxt.st = ptq_pkg::ST_PUL_N;
               end
            end else if (cls == ptq_pkg::CLS_RUNT) begin
               if (lo_r && !s_hi && pos_ok) begin
                  s_nxt.st = ptq_pkg::ST_RUNT_UP;
               end else if (hi_f && s_lo && neg_ok) begin
                  s_nxt.st = ptq_pkg::ST_RUNT_DN;
               end
            end else begin
               if (lo_r && !s_hi && pos_ok) begin
                  s_nxt.st = ptq_pkg::ST_SLEW_UP;
               end else if (hi_f && s_lo && neg_ok) begin
                  s_nxt.st = ptq_pkg::ST_SLEW_DN;
               end
            end
         end
         ptq_pkg::ST_PUL_P: begin
            if (lvl_f) begin
               hit = pul_ok;
               // with either polarity the closing edge opens a negative pulse
               s_nxt.st = neg_ok ? ptq_pkg::ST_PUL_N : ptq_pkg::ST_IDLE;
               s_nxt.cnt = 16'h0001;
            end else begin
               s_nxt.cnt = sat_inc(s_r.cnt);
            end
         end
         ptq_pkg::ST_PUL_N: begin
            if (lvl_r) begin
               hit = pul_ok;
               s_nxt.st = pos_ok ? ptq_pkg::ST_PUL_P : ptq_pkg::ST_IDLE;
               s_nxt.cnt = 16'h0001;
            end else begin
               s_nxt.cnt = sat_inc(s_r.cnt);
            end
         end
         ptq_pkg::ST_RUNT_UP: begin
            if (s_hi) begin
               s_nxt.st = ptq_pkg::ST_IDLE;
            end else if (lo_f) begin
               hit = 1'b1;
               s_nxt.st = ptq_pkg::ST_IDLE;
            end
         end
         ptq_pkg::ST_RUNT_DN: begin
            if (!s_lo) begin
               s_nxt.st = ptq_pkg::ST_IDLE;
            end else if (hi_r) begin
               hit = 1'b1;
               s_nxt.st = ptq_pkg::ST_IDLE;
            end
         end
         ptq_pkg::ST_SLEW_UP: begin
            if (hi_r) begin
               hit = slew_ok;
               s_nxt.st = ptq_pkg::ST_IDLE;
            end else if (lo_f) begin
               s_nxt.st = ptq_pkg::ST_IDLE;
            end else begin
               s_nxt.cnt = sat_inc(s_r.cnt);
            end
         end
         ptq_pkg::ST_SLEW_DN: begin
            if (lo_f) begin
               hit = slew_ok;
               s_nxt.st = ptq_pkg::ST_IDLE;
            end else if (hi_r) begin
               s_nxt.st = ptq_pkg::ST_IDLE;
            end else begin
               s_nxt.cnt = sat_inc(s_r.cnt);
            end
         end
         default: begin
            s_nxt.st = ptq_pkg::ST_IDLE;
         end
      endcase

      s_nxt.trig = hit;
      if (hit) begin
         s_nxt.tcnt = s_r.tcnt + 16'h0001;
      end

      // ---------------------------------------------
      // register writes
      // ---------------------------------------------
      if (wr) begin
         case (wb_adr_i)
            ptq_pkg::ADR_CTRL: begin
               nv = merge16({5'h00, s_r.ctl}, wb_dat_i, wb_sel_i);
               s_nxt.ctl = nv[ptq_pkg::CTL_W-1:0];
               // a half-way edge under a new setting must not qualify
               s_nxt.st = ptq_pkg::ST_IDLE;
               s_nxt.pk_start = (nv[ptq_pkg::CTL_LVM +: 2] == ptq_pkg::LVM_HALF);
            end
            ptq_pkg::ADR_GLW: begin
               s_nxt.glw = merge16(s_r.glw, wb_dat_i, wb_sel_i);
            end
            ptq_pkg::ADR_WLO: begin
               nv = merge16(s_r.wlo, wb_dat_i, wb_sel_i);
               s_nxt.wlo = (nv > s_r.whi) ? s_r.whi : nv;
            end
            ptq_pkg::ADR_WHI: begin
               nv = merge16(s_r.whi, wb_dat_i, wb_sel_i);
               s_nxt.whi = nv;
               if (s_r.wlo > nv) begin
                  s_nxt.wlo = nv;
               end
            end
            ptq_pkg::ADR_SLEW: begin
               s_nxt.slw = merge16(s_r.slw, wb_dat_i, wb_sel_i);
            end
            ptq_pkg::ADR_LVL: begin
               nv = merge16({8'h00, s_r.lvl}, wb_dat_i, wb_sel_i);
               s_nxt.lvl = nv[7:0];
            end
            default: begin
            end
         endcase
      end

      // ---------------------------------------------
      // effective trigger level
      // ---------------------------------------------
      case (s_r.ctl[ptq_pkg::CTL_LVM +: 2])
         ptq_pkg::LVM_MANUAL: s_nxt.lvl_eff = s_r.lvl;
         ptq_pkg::LVM_TTL: s_nxt.lvl_eff = ptq_pkg::LVL_TTL;
         ptq_pkg::LVM_ECL: s_nxt.lvl_eff = ptq_pkg::LVL_ECL;
         default: begin
            // previous level holds while the peak search runs
            if (pk_done) begin
               s_nxt.lvl_eff = pk_mid;
            end
         end
      endcase

      // ---------------------------------------------
      // bus answer: one wait-free cycle, unmapped reads zero
      // ---------------------------------------------
      s_nxt.ack = acc;
      s_nxt.dat = 32'h0000_0000;
      if (acc && !wb_we_i) begin
         case (wb_adr_i)
            ptq_pkg::ADR_CTRL: s_nxt.dat = {21'h000000, s_r.ctl};
            ptq_pkg::ADR_GLW: s_nxt.dat = {16'h0000, s_r.glw};
            ptq_pkg::ADR_WLO: s_nxt.dat = {16'h0000, s_r.wlo};
            ptq_pkg::ADR_WHI: s_nxt.dat = {16'h0000, s_r.whi};
            ptq_pkg::ADR_SLEW: s_nxt.dat = {16'h0000, s_r.slw};
            ptq_pkg::ADR_LVL: s_nxt.dat = {24'h000000, s_r.lvl};
            ptq_pkg::ADR_STAT: begin
               s_nxt.dat[7:0] = s_r.lvl_eff;
               s_nxt.dat[ptq_pkg::STAT_ST +: 3] = s_r.st;
               s_nxt.dat[ptq_pkg::STAT_BUSY] = pk_busy;
            end
            ptq_pkg::ADR_TCNT: s_nxt.dat = {16'h0000, s_r.tcnt};
            default: s_nxt.dat = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.st <= ptq_pkg::ST_IDLE;
         s_r.ctl <= ptq_pkg::RST_CTRL;
         s_r.glw <= ptq_pkg::RST_GLW;
         s_r.wlo <= ptq_pkg::RST_WLO;
         s_r.whi <= ptq_pkg::RST_WHI;
         s_r.slw <= ptq_pkg::RST_SLEW;
         s_r.lvl <= ptq_pkg::RST_LVL;
         s_r.lvl_eff <= ptq_pkg::RST_LVL;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o = s_r.dat;
   assign wb_ack_o = s_r.ack;
   assign trig_o = s_r.trig;
   assign level_o = s_r.lvl_eff;

endmodule

// ==== inc/ptq_pkg.sv ====
// constants, field layout and state types of the pulse trigger qualifier
//
// Contract
// - glitch positive: trigger on narrow positive pulse
// - glitch negative: trigger on narrow negative pulse
// - glitch either: narrow pulse of any polarity
// - accept narrower than width, reject wider
// - runt positive: rise lower, fall back, no upper
// - runt negative: fall upper, rise back, no lower
// - runt either: any direction, other threshold untouched
// - width positive: inside limits, or outside option
// - width negative: inside limits, or outside option
// - slew positive: lower crossed first, upper after
// - slew negative: upper crossed first, lower after
// - slew either: one threshold then the other
// - slew triggers on faster or slower transit
// - one source select of four, shared by classes
// - fifty percent preset finds peak midpoint
// - ttl/ecl presets fixed levels, manual uses entry
// - runt trigger at recrossing of first threshold
// - lower width limit kept at most upper
package ptq_pkg;

   // ---------------------------------------------
   // register byte offsets
   // ---------------------------------------------
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_GLW = 8'h04;
   localparam logic [7:0] ADR_WLO = 8'h08;
   localparam logic [7:0] ADR_WHI = 8'h0c;
   localparam logic [7:0] ADR_SLEW = 8'h10;
   localparam logic [7:0] ADR_LVL = 8'h14;
   localparam logic [7:0] ADR_STAT = 8'h18;
   localparam logic [7:0] ADR_TCNT = 8'h1c;

   // ---------------------------------------------
   // control and status field positions
   // ---------------------------------------------
   localparam int CTL_W = 11;
   localparam int CTL_CLS = 0;
   localparam int CTL_POL = 2;
   localparam int CTL_SRC = 4;
   localparam int CTL_REJ = 6;
   localparam int CTL_OUT = 7;
   localparam int CTL_SLOW = 8;
   localparam int CTL_LVM = 9;
   localparam int STAT_BUSY = 11;
   localparam int STAT_ST = 8;

   localparam logic [1:0] CLS_GLITCH = 2'h0;
   localparam logic [1:0] CLS_RUNT = 2'h1;
   localparam logic [1:0] CLS_WIDTH = 2'h2;
   localparam logic [1:0] CLS_SLEW = 2'h3;
   localparam logic [1:0] POL_POS = 2'h0;
   localparam logic [1:0] POL_NEG = 2'h1;
   localparam logic [1:0] POL_EITHER = 2'h2;
   localparam logic [1:0] LVM_MANUAL = 2'h0;
   localparam logic [1:0] LVM_TTL = 2'h1;
   localparam logic [1:0] LVM_ECL = 2'h2;
   localparam logic [1:0] LVM_HALF = 2'h3;

   // ---------------------------------------------
   // reset values and level presets (threshold dac codes)
   // ---------------------------------------------
   localparam logic [CTL_W-1:0] RST_CTRL = 11'h000;
   localparam logic [15:0] RST_GLW = 16'h0010;
   localparam logic [15:0] RST_WLO = 16'h0008;
   localparam logic [15:0] RST_WHI = 16'h0020;
   localparam logic [15:0] RST_SLEW = 16'h0010;
   localparam logic [7:0] RST_LVL = 8'h80;
   localparam logic [7:0] LVL_TTL = 8'h40;
   localparam logic [7:0] LVL_ECL = 8'h30;
   localparam logic [15:0] CNT_MAX = 16'hffff;

   // ---------------------------------------------
   // timing
   // ---------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int PEAK_WIN_NS = 2560;
   localparam logic [8:0] PEAK_CYC = 9'((PEAK_WIN_NS * CLK_MHZ) / 1000);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_PUL_P,
      ST_PUL_N,
      ST_RUNT_UP,
      ST_RUNT_DN,
      ST_SLEW_UP,
      ST_SLEW_DN
   } ptq_state_t;

endpackage

// ==== rtl/ptq_peak.sv ====
// peak finder: midpoint between max and min of a sample stream
`timescale 1ns/1ps
module ptq_peak (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [7:0] samp_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] mid_o
);

   typedef struct packed {
      logic busy;
      logic done;
      logic [8:0] cnt;
      logic [7:0] mx;
      logic [7:0] mn;
      logic [7:0] mid;
   } ptq_pk_t;

   ptq_pk_t s_r;
   ptq_pk_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (start_i) begin
         s_nxt.busy = 1'b1;
         s_nxt.cnt = ptq_pkg::PEAK_CYC;
         s_nxt.mx = samp_i;
         s_nxt.mn = samp_i;
      end else if (s_r.busy) begin
         if (samp_i > s_r.mx) begin
            s_nxt.mx = samp_i;
         end
         if (samp_i < s_r.mn) begin
            s_nxt.mn = samp_i;
         end
         s_nxt.cnt = s_r.cnt - 9'h001;
         if (s_r.cnt == 9'h001) begin
            // midpoint without overflow: sum carried in 9 bits
            s_nxt.mid = 8'(({1'b0, s_r.mx} + {1'b0, s_r.mn}) >> 1);
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy_o = s_r.busy;
   assign done_o = s_r.done;
   assign mid_o = s_r.mid;

endmodule

// ==== tb/ptq_chan_model.sv ====
// comparator model of four analog channels: level, upper and lower thresholds
`timescale 1ns/1ps
module ptq_chan_model #(
   parameter logic [7:0] LO_THR = 8'h40,
   parameter logic [7:0] HI_THR = 8'hc0
) (
   input wire logic clk_i,
   input wire logic [31:0] ana_i,
   input wire logic [7:0] level_i,
   output logic [3:0] cmp_lvl_o,
   output logic [3:0] cmp_hi_o,
   output logic [3:0] cmp_lo_o,
   output logic [31:0] samp_o
);
   // one cycle of comparator delay, same on every channel; outputs settle at the
   // first edge, the level outputs at the second, long before reset is released
   always @(posedge clk_i) begin
      samp_o <= ana_i;
      for (int n = 0; n < 4; n++) begin
         cmp_lvl_o[n] <= ana_i[8*n +: 8] > level_i;
         cmp_hi_o[n] <= ana_i[8*n +: 8] > HI_THR;
         cmp_lo_o[n] <= ana_i[8*n +: 8] > LO_THR;
      end
   end
endmodule

// ==== tb/ptq_checker.sv ====
// assertions on the ports of the pulse trigger qualifier
`timescale 1ns/1ps
module ptq_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic [3:0] cmp_lvl_i,
   input wire logic [3:0] cmp_hi_i,
   input wire logic [3:0] cmp_lo_i,
   input wire logic trig_o,
   input wire logic [7:0] level_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic ctl_wr;
   logic rd_req;
   assign ctl_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[1]
                   && wb_adr_i == ptq_pkg::ADR_CTRL;
   assign rd_req = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");
   a_ack_has_request: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without a request");
   a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   a_unmapped_reads_zero: assert property (rd_req && wb_adr_i == 8'h20 |=> wb_dat_o == 32'h0)
      else $error("unmapped read returned data");
   a_reset_clears_outputs: assert property ($fell(rst_i) |->
      !trig_o && !wb_ack_o && level_o == 8'h80)
      else $error("outputs not cleared by reset");
   // two sync flops, one edge compare, one output flop: trig_o is seen three ticks after
   // the tick at which the new comparator value is first sampled
   a_trig_has_cause: assert property (trig_o |->
      $past(cmp_lvl_i, 3) != $past(cmp_lvl_i, 4) || $past(cmp_hi_i, 3) != $past(cmp_hi_i, 4)
      || $past(cmp_lo_i, 3) != $past(cmp_lo_i, 4))
      else $error("trigger without a comparator transition three cycles before");
   a_ttl_preset_level: assert property (ctl_wr && wb_dat_i[10:9] == ptq_pkg::LVM_TTL
      |-> ##[1:4] level_o == ptq_pkg::LVL_TTL)
      else $error("ttl preset level not applied");
   a_ecl_preset_level: assert property (ctl_wr && wb_dat_i[10:9] == ptq_pkg::LVM_ECL
      |-> ##[1:4] level_o == ptq_pkg::LVL_ECL)
      else $error("ecl preset level not applied");
endmodule

bind ptq_top ptq_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_lvl_i(cmp_lvl_i),
   .cmp_hi_i(cmp_hi_i), .cmp_lo_i(cmp_lo_i), .trig_o(trig_o), .level_o(level_o));

// ==== tb/ptq_top_tb_top.sv ====
// testbench: register access and pulse stimulus through the comparator model
`timescale 1ns/1ps
module ptq_top_tb_top;
   localparam logic [1:0] GL = ptq_pkg::CLS_GLITCH;
   localparam logic [1:0] RU = ptq_pkg::CLS_RUNT;
   localparam logic [1:0] WD = ptq_pkg::CLS_WIDTH;
   localparam logic [1:0] SL = ptq_pkg::CLS_SLEW;
   localparam logic [1:0] PP = ptq_pkg::POL_POS;
   localparam logic [1:0] PN = ptq_pkg::POL_NEG;
   localparam logic [1:0] PE = ptq_pkg::POL_EITHER;
   // analog codes: below all, mid-low runt, mid-high runt, above all
   localparam logic [7:0] LO = 8'h10;
   localparam logic [7:0] MU = 8'h60;
   localparam logic [7:0] MD = 8'ha0;
   localparam logic [7:0] HI = 8'hf0;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic [3:0] cmp_lvl_i;
   logic [3:0] cmp_hi_i;
   logic [3:0] cmp_lo_i;
   logic [31:0] samp_i;
   logic trig_o;
   logic [7:0] level_o;
   logic [31:0] ana = 32'h0;
   logic [31:0] trig_all = 32'h0;
   int failures = 0;
   int cmp_count = 0;
   int exp_trig = 0;

   ptq_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cmp_lvl_i(cmp_lvl_i), .cmp_hi_i(cmp_hi_i),
      .cmp_lo_i(cmp_lo_i), .samp_i(samp_i), .trig_o(trig_o), .level_o(level_o));
   ptq_chan_model i_cmp (.clk_i(clk_i), .ana_i(ana), .level_i(level_o), .cmp_lvl_o(cmp_lvl_i),
      .cmp_hi_o(cmp_hi_i), .cmp_lo_o(cmp_lo_i), .samp_o(samp_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      if (trig_o === 1'b1) begin
         trig_all <= trig_all + 32'h1;
      end
   end

   // ---------------------------------------------
   // reporting and bus access
   // ---------------------------------------------
   task automatic end_sim();
      if (failures == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         failures++;
      end
   endtask
   // classic single cycle: request held until ack is sampled, then released
   task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                     output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'h3;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      if (wb_ack_o !== 1'b1) begin
         failures++;
         end_sim();
      end
   endtask
   task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
      logic [31:0] d;
      wb(1'b1, adr, dat, d);
   endtask
   task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] d;
      wb(1'b0, adr, 32'h0, d);
      chk($sformatf("register %h", adr), exp, d);
   endtask
   task automatic reg_defaults();
      logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
      logic [15:0] exp [9] = '{16'h0, 16'h10, 16'h8, 16'h20, 16'h10, 16'h80, 16'h80, 16'h0,
                               16'h0};
      for (int i = 0; i < 9; i++) begin
         rd(adr[i], {16'h0, exp[i]});
      end
   endtask
   task automatic lvchk(input logic [7:0] exp);
      repeat (6) @(posedge clk_i);
      chk("level", {24'h0, exp}, {24'h0, level_o});
   endtask

   // ---------------------------------------------
   // pulse runs: settle baseline, configure, one excursion, count triggers
   // ---------------------------------------------
   function automatic logic [10:0] cf(input logic [1:0] cls, input logic [1:0] pol,
                                      input int src, input int opt);
      return {2'h0, 3'(opt), 2'(src), pol, cls};
   endfunction
   task automatic run(input logic [10:0] ctl, input int ch, input logic [7:0] b,
                      input logic [7:0] v1, input int k, input logic [7:0] v2, input int exp);
      logic [31:0] t0;
      @(posedge clk_i);
      ana[8*ch +: 8] <= b;
      repeat (6) @(posedge clk_i);
      wr(ptq_pkg::ADR_CTRL, {21'h0, ctl});
      repeat (6) @(posedge clk_i);
      t0 = trig_all;
      ana[8*ch +: 8] <= v1;
      repeat (k) @(posedge clk_i);
      ana[8*ch +: 8] <= v2;
      repeat (10) @(posedge clk_i);
      chk("trigger count", 32'(exp), trig_all - t0);
      exp_trig += exp;
   endtask

   initial begin
      repeat (100000) @(posedge clk_i);
      failures++;
      end_sim();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      reg_defaults();
      wr(8'h20, 32'hffff);
      rd(8'h20, 32'h0);
      wr(ptq_pkg::ADR_GLW, 32'h4);
      wr(ptq_pkg::ADR_WLO, 32'h3);
      wr(ptq_pkg::ADR_WHI, 32'h5);
      wr(ptq_pkg::ADR_SLEW, 32'h4);
      run(cf(GL, PP, 0, 0), 0, LO, HI, 2, LO, 1);
      run(cf(GL, PP, 0, 0), 0, LO, HI, 4, LO, 0);
      run(cf(GL, PP, 0, 0), 0, HI, LO, 2, HI, 0);
      run(cf(GL, PN, 0, 0), 0, HI, LO, 2, HI, 1);
      run(cf(GL, PN, 0, 0), 0, LO, HI, 2, LO, 0);
      run(cf(GL, PE, 0, 0), 0, LO, HI, 2, LO, 1);
      run(cf(GL, PE, 0, 0), 0, HI, LO, 3, HI, 1);
      run(cf(GL, PP, 0, 1), 0, LO, HI, 6, LO, 1);
      run(cf(GL, PP, 0, 1), 0, LO, HI, 2, LO, 0);
      run(cf(GL, PN, 0, 1), 0, HI, LO, 6, HI, 1);
      run(cf(GL, PP, 2, 0), 2, LO, HI, 2, LO, 1);
      run(cf(RU, PP, 2, 0), 0, LO, MU, 3, LO, 0);
      run(cf(RU, PP, 2, 0), 2, LO, MU, 3, LO, 1);
      run(cf(RU, PP, 0, 0), 0, LO, MU, 3, LO, 1);
      run(cf(RU, PP, 0, 0), 0, LO, HI, 3, LO, 0);
      run(cf(RU, PN, 0, 0), 0, HI, MD, 3, HI, 1);
      run(cf(RU, PN, 0, 0), 0, HI, LO, 3, HI, 0);
      run(cf(RU, PE, 0, 0), 0, LO, MU, 3, LO, 1);
      run(cf(RU, PE, 0, 0), 0, HI, MD, 3, HI, 1);
      run(cf(WD, PP, 0, 0), 0, LO, HI, 2, LO, 0);
      run(cf(WD, PP, 0, 0), 0, LO, HI, 3, LO, 1);
      run(cf(WD, PP, 0, 0), 0, LO, HI, 5, LO, 1);
      run(cf(WD, PP, 0, 0), 0, LO, HI, 6, LO, 0);
      run(cf(WD, PP, 0, 2), 0, LO, HI, 2, LO, 1);
      run(cf(WD, PP, 0, 2), 0, LO, HI, 4, LO, 0);
      run(cf(WD, PP, 0, 2), 0, LO, HI, 6, LO, 1);
      run(cf(WD, PN, 0, 0), 0, HI, LO, 4, HI, 1);
      run(cf(WD, PN, 0, 2), 0, HI, LO, 6, HI, 1);
      run(cf(WD, PN, 0, 0), 0, LO, HI, 4, LO, 0);
      run(cf(SL, PP, 0, 0), 0, LO, MU, 2, HI, 1);
      run(cf(SL, PP, 0, 0), 0, LO, MU, 6, HI, 0);
      run(cf(SL, PP, 0, 4), 0, LO, MU, 6, HI, 1);
      run(cf(SL, PP, 0, 4), 0, LO, MU, 2, HI, 0);
      run(cf(SL, PP, 0, 0), 0, HI, MD, 2, LO, 0);
      run(cf(SL, PN, 0, 0), 0, HI, MD, 2, LO, 1);
      run(cf(SL, PN, 0, 0), 0, LO, MU, 2, HI, 0);
      run(cf(SL, PE, 0, 0), 0, HI, MD, 2, LO, 1);
      run(cf(SL, PE, 0, 0), 0, LO, MU, 2, HI, 1);
      wr(ptq_pkg::ADR_WLO, 32'h9);
      rd(ptq_pkg::ADR_WLO, 32'h5);
      wr(ptq_pkg::ADR_WHI, 32'h2);
      rd(ptq_pkg::ADR_WLO, 32'h2);
      rd(ptq_pkg::ADR_WHI, 32'h2);
      rd(ptq_pkg::ADR_TCNT, {16'h0, 16'(exp_trig)});
      wr(ptq_pkg::ADR_LVL, 32'h55);
      wr(ptq_pkg::ADR_CTRL, 32'h0);
      lvchk(8'h55);
      wr(ptq_pkg::ADR_CTRL, {21'h0, ptq_pkg::LVM_TTL, 9'h0});
      lvchk(ptq_pkg::LVL_TTL);
      wr(ptq_pkg::ADR_CTRL, {21'h0, ptq_pkg::LVM_ECL, 9'h0});
      lvchk(ptq_pkg::LVL_ECL);
      ana[7:0] <= LO;
      repeat (6) @(posedge clk_i);
      wr(ptq_pkg::ADR_CTRL, {21'h0, ptq_pkg::LVM_HALF, 9'h0});
      rd(ptq_pkg::ADR_STAT, {20'h0, 1'b1, 3'h0, ptq_pkg::LVL_ECL});
      repeat (20) @(posedge clk_i);
      ana[7:0] <= 8'hd0;
      repeat (20) @(posedge clk_i);
      ana[7:0] <= LO;
      repeat (300) @(posedge clk_i);
      chk("half level", 32'h70, {24'h0, level_o});
      // second reset in mid-run must bring every register back
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      reg_defaults();
      end_sim();
   end
endmodule
